// ---- core/vcs_caldiv.sv ----
// Calibration clock generator: reference edges divided by R, then by the calibration ratio
`timescale 1ns/1ps
`default_nettype none
`include "vcs_cfg.svh"
module vcs_caldiv (
  input  wire logic                    clock,     // System clock
  input  wire logic                    rst,       // Synchronous reset
  input  wire logic                    run,       // Count only while tuning
  input  wire logic                    ref_edge,  // Reference rising edge pulse
  input  wire logic [`VCS_RDIV_W-1:0]  r_div,     // R divide value
  input  wire logic [1:0]              div_sel,   // Calibration divider select
  output logic                         cal_tick   // One calibration clock cycle
);
  import vcs_pkg::*;

  logic [`VCS_RDIV_W-1:0] r_count;
  logic [4:0]             d_count;
  logic                   rdiv_pulse;
  logic                   div_wrap;

  // R of zero behaves as R of one
  assign rdiv_pulse = run & ref_edge & ((r_count + `VCS_RDIV_RST) >= r_div);
  assign div_wrap  = (d_count + 5'h01) >= vcs_div_ratio(div_sel);

  always_ff @(posedge clock) begin
    if (rst || !run) begin
      r_count <= '0;
    end else if (ref_edge) begin
      r_count <= rdiv_pulse ? '0 : r_count + `VCS_RDIV_RST;
    end
  end

  // No reference edges means no ticks: the sequencer simply waits
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      d_count <= '0;
    end else if (rdiv_pulse) begin
      d_count <= div_wrap ? '0 : d_count + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cal_tick <= 1'b0;
    end else begin
      cal_tick <= rdiv_pulse & div_wrap;
    end
  end

endmodule : vcs_caldiv
`default_nettype wire

// ---- core/vcs_cfg.svh ----
// Register indices, field positions, reset values and counts for the calibration sequencer
`ifndef VCS_CFG_SVH
`define VCS_CFG_SVH

// Register indices; byte address is four times the index
`define VCS_IDX_CALCTL     10'h018
`define VCS_IDX_STATUS     10'h01F
`define VCS_IDX_RDIV       10'h011
`define VCS_IDX_VCODIV     10'h1E0
`define VCS_IDX_UPDATE     10'h232

// Address slice of the bus byte address
`define VCS_ADR_HI         11
`define VCS_ADR_LO         2

// Calibration control fields
`define VCS_CAL_START      0
`define VCS_CALDIV_LSB     1
`define VCS_CALDIV_MSB     2
`define VCS_UPDATE_BIT     0

// Monitor and status fields
`define VCS_THR_REF1       0
`define VCS_THR_REF2       1
`define VCS_STAT_REF1_LOW  2
`define VCS_STAT_REF2_LOW  3
`define VCS_STAT_VCO_LOW   4
`define VCS_STAT_DONE      6

// Widths and reset values
`define VCS_RDIV_W         14
`define VCS_VCODIV_W       3
`define VCS_RDIV_RST       14'h0001
`define VCS_CALDIV_RST     2'h3
`define VCS_VCODIV_RST     3'h2

// Calibration length in calibration-clock cycles
`define VCS_CAL_CYCLES     13'h1130
`define VCS_CAL_CNT_W      13

// Monitor limits in system clock cycles without an input edge
`define VCS_MON_W          12
`define VCS_MON_LIMIT_NORM 12'h014
`define VCS_MON_LIMIT_EXT  12'h0C8

`endif

// ---- core/vcs_freq_mon.sv ----
// Frequency status monitor: flags an input whose edges come too far apart
`timescale 1ns/1ps
`default_nettype none
`include "vcs_cfg.svh"
module vcs_freq_mon (
  input  wire logic clock,    // System clock
  input  wire logic rst,      // Synchronous reset
  input  wire logic sig,      // Monitored clock, sampled
  input  wire logic ext_sel,  // Extended threshold select
  output logic      below     // Input below threshold frequency
);
  logic                 prev;
  logic                 rise;
  logic [`VCS_MON_W-1:0] gap;
  logic [`VCS_MON_W-1:0] limit;

  assign rise  = sig & ~prev;
  assign limit = ext_sel ? `VCS_MON_LIMIT_EXT : `VCS_MON_LIMIT_NORM;

  always_ff @(posedge clock) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= sig;
    end
  end

  // Gap counter saturates so a dead input stays flagged
  always_ff @(posedge clock) begin
    if (rst || rise) begin
      gap <= '0;
    end else if (gap < limit) begin
      gap <= gap + 12'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || rise) begin
      below <= 1'b0;
    end else begin
      below <= (gap >= limit);
    end
  end

endmodule : vcs_freq_mon
`default_nettype wire

// ---- core/vcs_pkg.sv ----
// Types and shared helper functions for the calibration sequencer
package vcs_pkg;

  typedef enum logic [2:0] {
    VCS_IDLE,
    VCS_HOLD,
    VCS_TUNE,
    VCS_RELEASE,
    VCS_CLOSE
  } vcs_state_t;

  // Calibration divider select to ratio: 2, 4, 8, 16
  function automatic logic [4:0] vcs_div_ratio(input logic [1:0] sel);
    vcs_div_ratio = 5'h02 << sel;
  endfunction : vcs_div_ratio

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] vcs_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    vcs_merge = res;
  endfunction : vcs_merge

endpackage : vcs_pkg

// ---- core/vcs_top.sv ----
// VCO calibration sequencer with frequency monitors and Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "vcs_cfg.svh"
module vcs_top (
  input  wire logic        clock,                       // System clock, 20 MHz
  input  wire logic        rst,                         // Synchronous reset, high
  // Wishbone slave
  input  wire logic        wb_cyc_i,                    // Bus cycle
  input  wire logic        wb_stb_i,                    // Strobe
  input  wire logic        wb_we_i,                     // Write enable
  input  wire logic [11:0] wb_adr_i,                    // Byte address
  input  wire logic [3:0]  wb_sel_i,                    // Byte lanes
  input  wire logic [31:0] wb_dat_i,                    // Write data
  output logic [31:0]      wb_dat_o,                    // Read data
  output logic             wb_ack_o,                    // Acknowledge
  // Clock inputs, sampled on clock
  input  wire logic        pll_reference_input_clock,   // Reference 1
  input  wire logic        pll_reference_input_clock_b, // Reference 2
  input  wire logic        vco_clock_sample,            // Divided VCO sample
  // Nonvolatile loader
  input  wire logic        nv_autoload_en,              // Store set to auto-load
  input  wire logic        nv_load_done,                // Load finished pulse
  // PLL and distribution controls
  output logic             out_sync_hold,               // Hold outputs static
  output logic             pll_loop_open,               // Loop open for tuning
  output logic             vco_tune_active,             // Tuning in progress
  output logic [2:0]       vco_div_sel                  // VCO divider field
);
  import vcs_pkg::*;

  // Staged registers, written by software
  logic                    stage_start;
  logic [1:0]              stage_div;
  // Active start and divider copies, loaded by the update strobe; R divide and thresholds written directly
  logic                    act_start;
  logic                    act_start_prev;
  logic [1:0]              act_div;
  logic [`VCS_RDIV_W-1:0]  r_div;
  logic [31:0]             rdiv_merged;
  logic [1:0]              thr_ext;
  logic                    cal_done;

  // Bus decode
  logic                    bus_req;
  logic                    bus_wr;
  logic [9:0]              reg_idx;
  logic [31:0]             next_rd;
  logic                    update_pulse;

  // Sequencer
  vcs_state_t              state;
  vcs_state_t              next_state;
  logic [`VCS_CAL_CNT_W-1:0] cal_count;
  logic                    cal_tick;
  logic                    cal_req;
  logic                    auto_pend;
  logic                    ref_prev;
  logic                    ref_edge;

  // Monitor flags
  logic                    ref1_low;
  logic                    ref2_low;
  logic                    vco_low;

  // ---------------- Register bus ----------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;
  assign reg_idx = wb_adr_i[`VCS_ADR_HI:`VCS_ADR_LO];

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Update strobe is self-clearing and reads back as zero
  assign update_pulse = bus_wr && (reg_idx == `VCS_IDX_UPDATE) &&
                        wb_sel_i[0] && wb_dat_i[`VCS_UPDATE_BIT];

  always_ff @(posedge clock) begin
    if (rst) begin
      stage_start <= 1'b0;
      stage_div   <= `VCS_CALDIV_RST;
    end else if (bus_wr && (reg_idx == `VCS_IDX_CALCTL) && wb_sel_i[0]) begin
      stage_start <= wb_dat_i[`VCS_CAL_START];
      stage_div   <= wb_dat_i[`VCS_CALDIV_MSB:`VCS_CALDIV_LSB];
    end
  end

  // Start bit and divider select reach the sequencer only through the update strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      act_start <= 1'b0;
      act_div   <= `VCS_CALDIV_RST;
    end else if (update_pulse) begin
      act_start <= stage_start;
      act_div   <= stage_div;
    end
  end

  assign rdiv_merged = vcs_merge({18'h00000, r_div}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clock) begin
    if (rst) begin
      r_div <= `VCS_RDIV_RST;
    end else if (bus_wr && (reg_idx == `VCS_IDX_RDIV)) begin
      r_div <= rdiv_merged[`VCS_RDIV_W-1:0];
    end
  end

  // Changing PLL settings here never starts a calibration
  always_ff @(posedge clock) begin
    if (rst) begin
      vco_div_sel <= `VCS_VCODIV_RST;
    end else if (bus_wr && (reg_idx == `VCS_IDX_VCODIV) && wb_sel_i[0]) begin
      vco_div_sel <= wb_dat_i[`VCS_VCODIV_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      thr_ext <= 2'h0;
    end else if (bus_wr && (reg_idx == `VCS_IDX_STATUS) && wb_sel_i[0]) begin
      thr_ext[0] <= wb_dat_i[`VCS_THR_REF1];
      thr_ext[1] <= wb_dat_i[`VCS_THR_REF2];
    end
  end

  // Read mux; unmapped indices answer with zero
  always_comb begin
    next_rd = 32'h0000_0000;
    case (reg_idx)
      `VCS_IDX_CALCTL: begin
        next_rd[`VCS_CAL_START] = stage_start;
        next_rd[`VCS_CALDIV_MSB:`VCS_CALDIV_LSB] = stage_div;
      end
      `VCS_IDX_STATUS: begin
        next_rd[`VCS_THR_REF1]      = thr_ext[0];
        next_rd[`VCS_THR_REF2]      = thr_ext[1];
        next_rd[`VCS_STAT_REF1_LOW] = ref1_low;
        next_rd[`VCS_STAT_REF2_LOW] = ref2_low;
        next_rd[`VCS_STAT_VCO_LOW]  = vco_low;
        next_rd[`VCS_STAT_DONE]     = cal_done;
      end
      `VCS_IDX_RDIV: begin
        next_rd[`VCS_RDIV_W-1:0] = r_div;
      end
      `VCS_IDX_VCODIV: begin
        next_rd[`VCS_VCODIV_W-1:0] = vco_div_sel;
      end
      default: begin
        next_rd = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= next_rd;
    end
  end

  // ---------------- Calibration requests ----------------
  always_ff @(posedge clock) begin
    if (rst) begin
      act_start_prev <= 1'b0;
    end else begin
      act_start_prev <= act_start;
    end
  end

  // A power-up load request waits until the sequencer is idle
  always_ff @(posedge clock) begin
    if (rst) begin
      auto_pend <= 1'b0;
    end else if (nv_load_done && nv_autoload_en) begin
      auto_pend <= 1'b1;
    end else if (state == VCS_IDLE) begin
      auto_pend <= 1'b0;
    end
  end

  // Only a zero-to-one of the active start bit, or the auto-load, starts
  assign cal_req = (act_start & ~act_start_prev) | auto_pend;

  // ---------------- Reference edge and calibration clock ----------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= pll_reference_input_clock;
    end
  end

  assign ref_edge = pll_reference_input_clock & ~ref_prev;

  vcs_caldiv u_caldiv (
    .clock    (clock),
    .rst      (rst),
    .run      (state == VCS_TUNE),
    .ref_edge (ref_edge),
    .r_div    (r_div),
    .div_sel  (act_div),
    .cal_tick (cal_tick)
  );

  // ---------------- Sequencer ----------------
  always_comb begin
    next_state = state;
    case (state)
      VCS_IDLE: begin
        if (cal_req) begin
          next_state = VCS_HOLD;
        end
      end
      VCS_HOLD: begin
        next_state = VCS_TUNE;
      end
      VCS_TUNE: begin
        // Stalls here with hold asserted while the reference is gone
        if (cal_tick && (cal_count == `VCS_CAL_CYCLES - 13'h0001)) begin
          next_state = VCS_RELEASE;
        end
      end
      VCS_RELEASE: begin
        next_state = VCS_CLOSE;
      end
      VCS_CLOSE: begin
        next_state = VCS_IDLE;
      end
      default: begin
        next_state = VCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= VCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state != VCS_TUNE) begin
      cal_count <= '0;
    end else if (cal_tick) begin
      cal_count <= cal_count + 13'h0001;
    end
  end

  // Hold set on entry, dropped before the loop closes
  always_ff @(posedge clock) begin
    if (rst) begin
      out_sync_hold <= 1'b0;
    end else if (state == VCS_IDLE && cal_req) begin
      out_sync_hold <= 1'b1;
    end else if (state == VCS_RELEASE) begin
      out_sync_hold <= 1'b0;
    end
  end

  // Loop closes one cycle after the hold releases; lock is not awaited
  always_ff @(posedge clock) begin
    if (rst) begin
      pll_loop_open <= 1'b0;
    end else if (state == VCS_HOLD) begin
      pll_loop_open <= 1'b1;
    end else if (state == VCS_CLOSE) begin
      pll_loop_open <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      vco_tune_active <= 1'b0;
    end else begin
      vco_tune_active <= (next_state == VCS_TUNE);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cal_done <= 1'b0;
    end else if (state == VCS_IDLE && cal_req) begin
      cal_done <= 1'b0;
    end else if (state == VCS_CLOSE) begin
      cal_done <= 1'b1;
    end
  end

  // ---------------- Frequency monitors ----------------
  vcs_freq_mon u_mon_ref1 (
    .clock   (clock),
    .rst     (rst),
    .sig     (pll_reference_input_clock),
    .ext_sel (thr_ext[0]),
    .below   (ref1_low)
  );

  vcs_freq_mon u_mon_ref2 (
    .clock   (clock),
    .rst     (rst),
    .sig     (pll_reference_input_clock_b),
    .ext_sel (thr_ext[1]),
    .below   (ref2_low)
  );

  // VCO monitor has only the normal threshold
  vcs_freq_mon u_mon_vco (
    .clock   (clock),
    .rst     (rst),
    .sig     (vco_clock_sample),
    .ext_sel (1'b0),
    .below   (vco_low)
  );

endmodule : vcs_top
`default_nettype wire

// ---- verification/vcs_top_properties.sv ----
// Port-level checks for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vcs_cfg.svh"
module vcs_top_properties (
  input wire logic        clock,                       // Clock
  input wire logic        rst,                         // Reset
  input wire logic        wb_cyc_i,                    // Cycle
  input wire logic        wb_stb_i,                    // Strobe
  input wire logic        wb_we_i,                     // Write
  input wire logic [11:0] wb_adr_i,                    // Address
  input wire logic [3:0]  wb_sel_i,                    // Lanes
  input wire logic [31:0] wb_dat_i,                    // Write data
  input wire logic [31:0] wb_dat_o,                    // Read data
  input wire logic        wb_ack_o,                    // Ack
  input wire logic        pll_reference_input_clock,   // Ref 1
  input wire logic        pll_reference_input_clock_b, // Ref 2
  input wire logic        vco_clock_sample,            // VCO
  input wire logic        nv_autoload_en,              // Auto-load
  input wire logic        nv_load_done,                // Load done
  input wire logic        out_sync_hold,               // Hold
  input wire logic        pll_loop_open,               // Loop open
  input wire logic        vco_tune_active,             // Tuning
  input wire logic [2:0]  vco_div_sel                  // VCO divider
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic       req;
  logic       rd_stat;
  logic       wr_vdiv;
  logic [2:0] wdat3;
  logic       armed;
  logic       hold_d;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_stat = req && !wb_we_i && wb_adr_i[11:2] == `VCS_IDX_STATUS;
  assign wr_vdiv = req && wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == `VCS_IDX_VCODIV;
  assign wdat3 = wb_dat_i[2:0];
  // Armed by an update or a load; a looser bound, since ignored requests also arm
  always_ff @(posedge clock) begin
    if (rst) begin
      armed <= 1'b0;
      hold_d <= 1'b0;
    end else begin
      hold_d <= out_sync_hold;
      if ((nv_load_done && nv_autoload_en) ||
          (req && wb_we_i && wb_adr_i[11:2] == `VCS_IDX_UPDATE)) begin
        armed <= 1'b1;
      end else if (out_sync_hold && !hold_d) begin
        armed <= 1'b0;
      end
    end
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("ack missing");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  hold_then_open_a: assert property (
      !$past(rst) && $rose(out_sync_hold) |=> pll_loop_open && vco_tune_active)
    else $error("loop not opened after hold");
  tune_in_hold_a: assert property (vco_tune_active |-> out_sync_hold && pll_loop_open)
    else $error("tuning outside hold");
  release_close_a: assert property (
      !$past(rst) && $fell(out_sync_hold) |->
      pll_loop_open && !vco_tune_active ##1 !pll_loop_open)
    else $error("release order wrong");
  done_low_run_a: assert property (
      wb_ack_o && $past(rd_stat) && $past(out_sync_hold) |-> !wb_dat_o[`VCS_STAT_DONE])
    else $error("done high while running");
  no_self_start_a: assert property (
      !$past(rst) && $rose(out_sync_hold) |-> $past(armed))
    else $error("calibration without request");
  vdiv_write_a: assert property (wr_vdiv |=> ##1 vco_div_sel == $past(wdat3, 2))
    else $error("divider field not stored");
  reset_vals_a: assert property (disable iff (1'b0)
      rst |=> vco_div_sel == `VCS_VCODIV_RST && !out_sync_hold && !pll_loop_open && !wb_ack_o)
    else $error("reset values wrong");
  cal_start_c: cover property ($rose(out_sync_hold));
  cal_end_c: cover property ($fell(pll_loop_open));
  stat_read_c: cover property (wb_ack_o && $past(rd_stat));
endmodule : vcs_top_properties
`default_nettype wire

// ---- verification/vcs_top_tb.sv ----
// Self-checking bench for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module vcs_top_tb;
  import vcs_pkg::*;
  logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [31:0] lfsr = 32'h00012EF4;
  logic pll_reference_input_clock = 1'b0, pll_reference_input_clock_b = 1'b0;
  logic vco_clock_sample = 1'b0;
  logic nv_autoload_en, nv_load_done, out_sync_hold, pll_loop_open, vco_tune_active;
  logic [2:0]  vco_div_sel, v;
  logic r1_run, rb_run, vc_run;
  logic r1_d = 1'b0;
  int num_errors, samples_checked, edges, n;
  logic [9:0]  ri [6] = '{10'h018, 10'h01F, 10'h011, 10'h1E0, 10'h232, 10'h3FF};
  logic [31:0] rv [6] = '{32'h6, 32'h0, 32'h1, 32'h2, 32'h0, 32'h0};
  vcs_top u_vcs_top (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pll_reference_input_clock(pll_reference_input_clock),
    .pll_reference_input_clock_b(pll_reference_input_clock_b),
    .vco_clock_sample(vco_clock_sample), .nv_autoload_en(nv_autoload_en),
    .nv_load_done(nv_load_done), .out_sync_hold(out_sync_hold),
    .pll_loop_open(pll_loop_open), .vco_tune_active(vco_tune_active),
    .vco_div_sel(vco_div_sel)
  );
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic int exp_edges(input logic [1:0] s, input int r);
    exp_edges = 4400 * r * (2 << s);
  endfunction : exp_edges
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d,
                    input logic [3:0] sel);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= sel;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    check(k, 32'h2); // Ack one cycle after the taken edge; a hang ends at the watchdog
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic wait_hold(input logic lv, input int mx);
    n = 0;
    while (out_sync_hold !== lv && n < mx) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_hold
  // Manual start or auto-load; ref edges seen while tuning are counted
  task automatic cal(input logic [1:0] s, input int r, input logic stall, input logic auto);
    wb(1'b1, 10'h011, 32'(r), 4'h3);
    if (auto) begin
      nv_load_done <= 1'b1;
      @(posedge clock);
      nv_load_done <= 1'b0;
    end else begin
      wb(1'b1, 10'h018, {29'h0, s, 1'b1}, 4'h1);
      wb(1'b1, 10'h232, 32'h1, 4'h1);
    end
    wait_hold(1'b1, 6);
    check(out_sync_hold, 1'b1);
    wb(1'b0, 10'h01F, 32'h0, 4'hF);
    check(rd[6], 1'b0);
    if (stall) begin
      repeat (2000) @(posedge clock);
      r1_run <= 1'b0;
      repeat (300) @(posedge clock);
      wb(1'b0, 10'h01F, 32'h0, 4'hF);
      check(rd[6:2], 5'h01);
      check(out_sync_hold, 1'b1);
      r1_run <= 1'b1;
    end
    wait_hold(1'b0, 40000);
    n = exp_edges(s, r);
    check(edges >= n - 4 && edges <= n + 4, 1'b1);
    @(posedge clock);
    wb(1'b0, 10'h01F, 32'h0, 4'hF);
    check(rd[6], 1'b1);
  endtask : cal
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Ref 2 and VCO get random gaps, kept well under the normal limit
  always @(posedge clock) begin
    lfsr <= lfsr_next(lfsr);
    r1_d <= pll_reference_input_clock;
    if (r1_run) begin
      pll_reference_input_clock <= ~pll_reference_input_clock;
    end
    pll_reference_input_clock_b <= rb_run & ~pll_reference_input_clock_b &
                                   (lfsr[3] | lfsr[8] | lfsr[13]);
    vco_clock_sample <= vc_run & ~vco_clock_sample & (lfsr[2] | lfsr[5] | lfsr[11]);
    // Count restarts in the hold-only step, so one process owns it
    if (out_sync_hold && !pll_loop_open) begin
      edges <= 0;
    end else if (vco_tune_active && pll_reference_input_clock && !r1_d) begin
      edges <= edges + 1;
    end
  end
  initial begin
    repeat (95000) @(posedge clock);
    num_errors++;
    print_verdict();
  end
  initial begin
    {rst, r1_run, rb_run, vc_run} = 4'hF;
    {wb_cyc_i, wb_stb_i, wb_we_i, nv_autoload_en, nv_load_done} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 48'h0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    check({out_sync_hold, pll_loop_open, vco_tune_active, vco_div_sel}, 6'h02);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, ri[i], 32'h0, 4'hF);
      check(rd, rv[i]);
    end
    repeat (3) begin
      v = lfsr[2:0];
      wb(1'b1, 10'h1E0, {29'h0, v}, 4'h1);
      check(vco_div_sel, v);
      wb(1'b1, 10'h1E0, {29'h0, ~v}, 4'h2);
      wb(1'b0, 10'h1E0, 32'h0, 4'hF);
      check(rd, {29'h0, v});
    end
    wb(1'b1, 10'h1E0, 32'h1, 4'h1);
    wb(1'b1, 10'h01F, 32'h43, 4'h1);
    wb(1'b0, 10'h01F, 32'h0, 4'hF);
    check(rd, 32'h3);
    {rb_run, vc_run} <= 2'h0;
    repeat (40) @(posedge clock);
    wb(1'b0, 10'h01F, 32'h0, 4'hF);
    check(rd[4:2], 3'h4);
    repeat (200) @(posedge clock);
    wb(1'b0, 10'h01F, 32'h0, 4'hF);
    check(rd[4:2], 3'h6);
    {rb_run, vc_run} <= 2'h3;
    wb(1'b1, 10'h01F, 32'h0, 4'h1);
    repeat (10) @(posedge clock);
    wb(1'b0, 10'h01F, 32'h0, 4'hF);
    check(rd, 32'h0);
    wb(1'b1, 10'h011, 32'h3, 4'h3);
    wb(1'b1, 10'h232, 32'h1, 4'h1);
    nv_load_done <= 1'b1;
    @(posedge clock);
    nv_load_done <= 1'b0;
    wait_hold(1'b1, 20);
    check(out_sync_hold, 1'b0);
    cal(2'h0, 1, 1'b1, 1'b0);
    wb(1'b1, 10'h232, 32'h1, 4'h1);
    wait_hold(1'b1, 20);
    check(out_sync_hold, 1'b0);
    wb(1'b1, 10'h018, 32'h0, 4'h1);
    wb(1'b1, 10'h232, 32'h1, 4'h1);
    cal(2'h1, 1, 1'b0, 1'b0);
    wb(1'b1, 10'h018, 32'h0, 4'h1);
    wb(1'b1, 10'h232, 32'h1, 4'h1);
    nv_autoload_en <= 1'b1;
    cal(2'h0, 1, 1'b0, 1'b1);
    print_verdict();
  end
endmodule : vcs_top_tb
bind vcs_top vcs_top_properties u_vcs_top_properties (
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pll_reference_input_clock(pll_reference_input_clock),
  .pll_reference_input_clock_b(pll_reference_input_clock_b),
  .vco_clock_sample(vco_clock_sample), .nv_autoload_en(nv_autoload_en),
  .nv_load_done(nv_load_done), .out_sync_hold(out_sync_hold),
  .pll_loop_open(pll_loop_open), .vco_tune_active(vco_tune_active),
  .vco_div_sel(vco_div_sel)
);
`default_nettype wire
